// >>> hdl/epiu_pkg.sv
// constants for the external pin interrupt unit
package epiu_pkg;
   // word indices, byte address is index times four (printed offsets 0x15 and 0x3b are not multiples of four)
   localparam logic [7:0]  IDX_PIN_CHANGE_MASK = 8'h15;
   localparam logic [7:0]  IDX_IRQ_ENABLE      = 8'h3b;
   localparam logic [7:0]  IDX_MCU_CONTROL     = 8'h35;
   localparam logic [7:0]  IDX_IRQ_FLAGS       = 8'h3a;
   localparam logic [7:0]  IDX_CORE_CTRL       = 8'h40;
   localparam logic [7:0]  IDX_PIN_STATUS      = 8'h41;
   localparam logic [7:0]  IDX_IRQ_MASK        = 8'h42;
   localparam logic [9:0]  ADDR_PIN_CHANGE_MASK = {IDX_PIN_CHANGE_MASK, 2'b00};
   localparam logic [9:0]  ADDR_IRQ_ENABLE      = {IDX_IRQ_ENABLE, 2'b00};
   localparam logic [9:0]  ADDR_MCU_CONTROL     = {IDX_MCU_CONTROL, 2'b00};
   localparam logic [9:0]  ADDR_IRQ_FLAGS       = {IDX_IRQ_FLAGS, 2'b00};
   localparam logic [9:0]  ADDR_CORE_CTRL       = {IDX_CORE_CTRL, 2'b00};
   localparam logic [9:0]  ADDR_PIN_STATUS      = {IDX_PIN_STATUS, 2'b00};
   localparam logic [9:0]  ADDR_IRQ_MASK        = {IDX_IRQ_MASK, 2'b00};
   // field positions
   localparam int          BIT_EXT_ENABLE  = 6;
   localparam int          BIT_PC_ENABLE   = 5;
   localparam int          BIT_EXT_FLAG    = 6;
   localparam int          BIT_PC_FLAG     = 5;
   localparam int          BIT_GLOBAL_EN   = 0;
   localparam int          BIT_IO_CLK_RUN  = 1;
   // reset values and writable masks
   localparam logic [7:0]  RST_PIN_CHANGE_MASK = 8'h3f;
   localparam logic [7:0]  RST_IRQ_ENABLE      = 8'h00;
   localparam logic [7:0]  RST_MCU_CONTROL     = 8'h00;
   localparam logic [7:0]  RST_CORE_CTRL       = 8'h02;
   localparam logic [7:0]  WMASK_PIN_CHANGE    = 8'h3f;
   localparam logic [7:0]  WMASK_IRQ_ENABLE    = 8'h60;
   localparam logic [7:0]  WMASK_MCU_CONTROL   = 8'h03;
   localparam logic [7:0]  WMASK_CORE_CTRL     = 8'h03;
   localparam logic [7:0]  WMASK_FLAGS         = 8'h60;
   // vectors
   localparam logic [3:0]  VEC_NONE  = 4'h0;
   localparam logic [3:0]  VEC_EXT   = 4'h2;
   localparam logic [3:0]  VEC_PC    = 4'h3;
   // axi responses
   localparam logic [1:0]  RESP_OKAY   = 2'b00;
   localparam logic [1:0]  RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {
      SENSE_LOW     = 2'b00,
      SENSE_ANY     = 2'b01,
      SENSE_FALLING = 2'b10,
      SENSE_RISING  = 2'b11
   } epiu_sense_e;
endpackage : epiu_pkg

// >>> hdl/epiu_top.sv
// external pin interrupt unit with axi4-lite register slave
// Behaviour
// [R1] pin activity raises requests even when pins are driven as outputs
// [R2] any toggle on a masked-in pin-change input sets the shared request
// [R3] pin change detection needs no io clock, so it wakes any sleep
// [R4] enabled level mode requests for as long as the pin stays low
// [R5] edges on the external pin are seen only while io clock runs
// [R6] low level is seen without io clock, waking from deep sleep
// [R7] level gone before start-up still wakes; no interrupt then taken
// [R8] sense select: 00 low, 01 any change, 10 falling, 11 rising
// [R9] pin sampled before edge detection; pulses over one clock caught
// [R10] driver must hold low level until current instruction completes
// [R11] request to core needs global enable and matching enable bit
// [R12] enable register: bit 6 external, bit 5 pin change, own vectors
// [R13] external flag sets on edge, clears on entry or write one, zero in level
// [R14] pin change flag sets on change, clears on entry or write one; here it sets only while enable bit 5 is on
// [R15] six mask bits gate pin change inputs, reset to one
// [R16] unused bits ignore writes and read zero
// [R17] external request is vector 2, pin change vector 3
// [R18] external pin passes a two-stage synchroniser before edge compare
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
module epiu_top #(
   parameter int PC_WIDTH = 6
) (
   input  wire logic                clk,
   input  wire logic                reset,
   input  wire logic                ext_irq_pin,
   input  wire logic [PC_WIDTH-1:0] pin_change_inputs,
   input  wire logic                irq_ack,
   input  wire logic [3:0]          irq_ack_vector,
   input  wire logic [11:0]         s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [11:0]         s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   output logic                     irq_request,
   output logic [3:0]               irq_vector,
   output logic                     wake_request,
   output logic                     irq
);

   typedef struct packed {
      logic [7:0]          pc_mask;
      logic [7:0]          enable;
      logic [7:0]          control;
      logic [7:0]          flags;
      logic [7:0]          core_ctrl;
      logic [7:0]          status_mask;
      logic                ext_meta;
      logic                ext_sync;
      logic                ext_prev;
      logic [PC_WIDTH-1:0] pc_prev;
      logic                aw_held;
      logic [9:0]          aw_addr;
      logic                w_held;
      logic [31:0]         w_data;
      logic [3:0]          w_strb;
      logic                awready;
      logic                wready;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                arready;
      logic                rvalid;
      logic [31:0]         rdata;
      logic [1:0]          rresp;
      logic                irq_request;
      logic [3:0]          irq_vector;
      logic                wake_request;
      logic                irq;
   } epiu_state_s;

   epiu_state_s st;
   epiu_state_s next_st;

   epiu_pkg::epiu_sense_e sense;
   logic                  io_clk_run;
   logic                  global_en;
   logic                  ext_edge;
   logic                  level_low;
   logic                  pc_change;
   logic                  do_write;
   logic [7:0]            wbyte;
   logic [7:0]            rbyte;
   logic                  rd_hit;
   logic                  wr_hit;
   logic [7:0]            live_flags;
   logic                  ext_pend;
   logic                  pc_pend;

   assign sense      = epiu_pkg::epiu_sense_e'(st.control[1:0]); // see [R8]
   assign io_clk_run = st.core_ctrl[epiu_pkg::BIT_IO_CLK_RUN];
   assign global_en  = st.core_ctrl[epiu_pkg::BIT_GLOBAL_EN];
   assign wbyte      = st.w_data[7:0];

   // synchronised level compared with its previous sample; edges are only
   // trusted while the io clock is said to run, as in the real sleep modes
   always_comb begin
      ext_edge = 1'b0;
      unique case (sense)
         epiu_pkg::SENSE_LOW:     ext_edge = 1'b0;
         epiu_pkg::SENSE_ANY:     ext_edge = st.ext_sync ^ st.ext_prev;
         epiu_pkg::SENSE_FALLING: ext_edge = st.ext_prev & ~st.ext_sync;
         epiu_pkg::SENSE_RISING:  ext_edge = ~st.ext_prev & st.ext_sync;
      endcase
      ext_edge = ext_edge & io_clk_run; // see [R5] [R9]
   end

   // level and pin change read the raw inputs so they work with io clock off;
   // inputs are taken as synchronous here, so no extra stage is needed
   assign level_low = (sense == epiu_pkg::SENSE_LOW) & ~ext_irq_pin; // see [R6]
   assign pc_change = |((pin_change_inputs ^ st.pc_prev)
                       & st.pc_mask[PC_WIDTH-1:0]); // see [R2] [R3] [R15]

   // level mode flag reads as clear, the request follows the pin directly
   assign ext_pend = st.enable[epiu_pkg::BIT_EXT_ENABLE]
                   & (level_low | st.flags[epiu_pkg::BIT_EXT_FLAG]); // see [R4]
   assign pc_pend  = st.enable[epiu_pkg::BIT_PC_ENABLE]
                   & st.flags[epiu_pkg::BIT_PC_FLAG];

   always_comb begin
      live_flags = st.flags;
      if (sense == epiu_pkg::SENSE_LOW) begin
         live_flags[epiu_pkg::BIT_EXT_FLAG] = 1'b0; // see [R13]
      end
   end

   always_comb begin
      rd_hit = 1'b1;
      rbyte  = 8'h00;
      unique case (s_axi_araddr[9:0])
         epiu_pkg::ADDR_PIN_CHANGE_MASK: rbyte = st.pc_mask;
         epiu_pkg::ADDR_IRQ_ENABLE:      rbyte = st.enable;
         epiu_pkg::ADDR_MCU_CONTROL:     rbyte = st.control;
         epiu_pkg::ADDR_IRQ_FLAGS:       rbyte = live_flags;
         epiu_pkg::ADDR_CORE_CTRL:       rbyte = st.core_ctrl;
         epiu_pkg::ADDR_IRQ_MASK:        rbyte = st.status_mask;
         epiu_pkg::ADDR_PIN_STATUS:
            rbyte = {1'b0, st.ext_sync, pin_change_inputs};
         default:                        rd_hit = 1'b0;
      endcase
      if (s_axi_araddr[11:10] != 2'b00) begin
         rd_hit = 1'b0;
      end
   end

   assign do_write = st.aw_held & st.w_held & ~st.bvalid;
   always_comb begin
      unique case (st.aw_addr)
         epiu_pkg::ADDR_PIN_CHANGE_MASK,
         epiu_pkg::ADDR_IRQ_ENABLE,
         epiu_pkg::ADDR_MCU_CONTROL,
         epiu_pkg::ADDR_IRQ_FLAGS,
         epiu_pkg::ADDR_CORE_CTRL,
         epiu_pkg::ADDR_PIN_STATUS,
         epiu_pkg::ADDR_IRQ_MASK: wr_hit = 1'b1;
         default:                 wr_hit = 1'b0;
      endcase
   end

   always_comb begin
      next_st = st;
      // two-stage synchroniser; only the second stage feeds the compare
      next_st.ext_meta = ext_irq_pin; // see [R18]
      next_st.ext_sync = st.ext_meta;
      next_st.ext_prev = st.ext_sync;
      next_st.pc_prev  = pin_change_inputs; // see [R1]

      // write channel: address and data taken in either order
      // ready must not wait for valid to drop, or a holding master stalls
      next_st.awready = ~st.aw_held;
      next_st.wready  = ~st.w_held;
      if (s_axi_awvalid & st.awready) begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = s_axi_awaddr[9:0];
         next_st.awready = 1'b0;
      end
      if (s_axi_wvalid & st.wready) begin
         next_st.w_held = 1'b1;
         next_st.w_data = s_axi_wdata;
         next_st.w_strb = s_axi_wstrb;
         next_st.wready = 1'b0;
      end
      if (do_write & st.w_strb[0]) begin
         unique case (st.aw_addr)
            epiu_pkg::ADDR_PIN_CHANGE_MASK:
               next_st.pc_mask = wbyte & epiu_pkg::WMASK_PIN_CHANGE; // see [R16]
            epiu_pkg::ADDR_IRQ_ENABLE:
               next_st.enable = wbyte & epiu_pkg::WMASK_IRQ_ENABLE; // see [R12]
            epiu_pkg::ADDR_MCU_CONTROL:
               next_st.control = wbyte & epiu_pkg::WMASK_MCU_CONTROL;
            epiu_pkg::ADDR_IRQ_FLAGS:
               next_st.flags = st.flags & ~(wbyte & epiu_pkg::WMASK_FLAGS);
            epiu_pkg::ADDR_CORE_CTRL:
               next_st.core_ctrl = wbyte & epiu_pkg::WMASK_CORE_CTRL;
            epiu_pkg::ADDR_IRQ_MASK:
               next_st.status_mask = wbyte & epiu_pkg::WMASK_FLAGS;
            default: ;
         endcase
      end
      if (do_write) begin
         next_st.aw_held = 1'b0;
         next_st.w_held  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = wr_hit ? epiu_pkg::RESP_OKAY
                                  : epiu_pkg::RESP_SLVERR;
      end
      if (st.bvalid & s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end

      // read channel: one cycle after the address is taken
      next_st.arready = ~st.rvalid;
      if (s_axi_arvalid & st.arready) begin
         next_st.arready = 1'b0;
         next_st.rvalid  = 1'b1;
         next_st.rdata   = {24'h00_0000, rbyte};
         next_st.rresp   = rd_hit ? epiu_pkg::RESP_OKAY
                                  : epiu_pkg::RESP_SLVERR;
      end
      if (st.rvalid & s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end

      // handler entry clears its own flag; a new event the same cycle wins
      if (irq_ack & (irq_ack_vector == epiu_pkg::VEC_EXT)) begin
         next_st.flags[epiu_pkg::BIT_EXT_FLAG] = 1'b0; // see [R13]
      end
      if (irq_ack & (irq_ack_vector == epiu_pkg::VEC_PC)) begin
         next_st.flags[epiu_pkg::BIT_PC_FLAG] = 1'b0; // see [R14]
      end
      if (ext_edge) begin
         next_st.flags[epiu_pkg::BIT_EXT_FLAG] = 1'b1; // see [R13]
      end
      if (pc_change & st.enable[epiu_pkg::BIT_PC_ENABLE]) begin
         next_st.flags[epiu_pkg::BIT_PC_FLAG] = 1'b1; // see [R14] [R15]
      end
      if (sense == epiu_pkg::SENSE_LOW) begin
         next_st.flags[epiu_pkg::BIT_EXT_FLAG] = 1'b0;
      end

      // external request has priority by its lower vector number
      next_st.irq_request = global_en & (ext_pend | pc_pend); // see [R11]
      if (global_en & ext_pend) begin
         next_st.irq_vector = epiu_pkg::VEC_EXT; // see [R17]
      end else if (global_en & pc_pend) begin
         next_st.irq_vector = epiu_pkg::VEC_PC;
      end else begin
         next_st.irq_vector = epiu_pkg::VEC_NONE;
      end
      // wake needs no global enable: a short low level still wakes the core
      // even if no request is left by the time it runs again
      next_st.wake_request = ext_pend | pc_pend; // see [R7]
      next_st.irq = |(live_flags & st.status_mask);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st             <= '0;
         st.pc_mask     <= epiu_pkg::RST_PIN_CHANGE_MASK; // see [R15]
         st.enable      <= epiu_pkg::RST_IRQ_ENABLE;
         st.control     <= epiu_pkg::RST_MCU_CONTROL;
         st.core_ctrl   <= epiu_pkg::RST_CORE_CTRL;
         st.ext_meta    <= 1'b1;
         st.ext_sync    <= 1'b1;
         st.ext_prev    <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign s_axi_awready = st.awready;
   assign s_axi_wready  = st.wready;
   assign s_axi_bvalid  = st.bvalid;
   assign s_axi_bresp   = st.bresp;
   assign s_axi_arready = st.arready;
   assign s_axi_rvalid  = st.rvalid;
   assign s_axi_rdata   = st.rdata;
   assign s_axi_rresp   = st.rresp;
   assign irq_request   = st.irq_request;
   assign irq_vector    = st.irq_vector;
   assign wake_request  = st.wake_request;
   assign irq           = st.irq;

endmodule : epiu_top

// >>> sim/epiu_top_sva.sv
// port-level assertions for the external pin interrupt unit
`timescale 1ns/1ns
module epiu_top_sva (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        irq_request,
   input wire logic [3:0]  irq_vector,
   input wire logic        wake_request,
   input wire logic        irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_write_answer: assert property (s_wr_both |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_read_answer: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
   a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 0)
      else $error("upper read bits set");
   a_vector_legal: assert property (irq_request |-> irq_vector ==
      epiu_pkg::VEC_EXT || irq_vector == epiu_pkg::VEC_PC)
      else $error("bad vector");
   a_req_wakes: assert property (irq_request |-> wake_request)
      else $error("request without pending source");
   a_idle_vector: assert property (!wake_request
      |-> irq_vector == epiu_pkg::VEC_NONE && !irq_request)
      else $error("vector without source");
   a_reset_quiet: assert property ($fell(reset) |-> !irq_request && !irq
      && !wake_request && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs active after reset");
endmodule : epiu_top_sva

// >>> sim/epiu_core_model.sv
// processor core model that enters handlers after a chosen latency
`timescale 1ns/1ns
module epiu_core_model (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        auto_ack,
   input wire logic [3:0]  latency,
   input wire logic        irq_request,
   input wire logic [3:0]  irq_vector,
   output logic            irq_ack,
   output logic [3:0]      irq_ack_vector,
   output logic [7:0]      ack_count
);
   logic [3:0] wait_cnt;
   always_ff @(posedge clk) begin
      irq_ack <= 1'b0;
      // vector wanders while no handler is entered
      irq_ack_vector <= irq_ack_vector + 4'h1;
      if (reset) begin
         wait_cnt <= 4'h0;
         ack_count <= 8'h00;
         irq_ack_vector <= 4'h0;
      end else if (auto_ack && irq_request && !irq_ack) begin
         if (wait_cnt == latency) begin
            irq_ack <= 1'b1;
            irq_ack_vector <= irq_vector;
            ack_count <= ack_count + 8'h01;
            wait_cnt <= 4'h0;
         end else begin
            wait_cnt <= wait_cnt + 4'h1;
         end
      end
   end
endmodule : epiu_core_model

// >>> sim/epiu_top_bench.sv
// register-level testbench for the external pin interrupt unit
`timescale 1ns/1ns
module epiu_top_bench;
   localparam logic [11:0] PCM = {2'b00, epiu_pkg::ADDR_PIN_CHANGE_MASK};
   localparam logic [11:0] IEN = {2'b00, epiu_pkg::ADDR_IRQ_ENABLE};
   localparam logic [11:0] MCU = {2'b00, epiu_pkg::ADDR_MCU_CONTROL};
   localparam logic [11:0] FLG = {2'b00, epiu_pkg::ADDR_IRQ_FLAGS};
   localparam logic [11:0] CTL = {2'b00, epiu_pkg::ADDR_CORE_CTRL};
   localparam logic [11:0] MSK = {2'b00, epiu_pkg::ADDR_IRQ_MASK};
   logic clk = 1'b0, reset = 1'b1, pin = 1'b1, ack_on = 1'b0;
   logic [5:0] pci = 6'h00;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0000_0000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   wire logic awready, wready, bvalid, arready, rvalid, ireq, wake, irq, ack;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [3:0] ivec, avec;
   wire logic [7:0] acks;
   logic [7:0] d;
   logic [1:0] r;
   logic [1:0] sense [6] = '{2'b10, 2'b10, 2'b11, 2'b11, 2'b01, 2'b01};
   logic pv [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
   logic [7:0] fe [6] = '{8'h40, 8'h00, 8'h00, 8'h40, 8'h40, 8'h40};
   int fail_count = 0, comparisons = 0, cycles = 0;
   always #25 clk = ~clk;
   epiu_top i_dut (.clk(clk), .reset(reset), .ext_irq_pin(pin),
      .pin_change_inputs(pci), .irq_ack(ack), .irq_ack_vector(avec),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_request(ireq),
      .irq_vector(ivec), .wake_request(wake), .irq(irq));
   epiu_core_model i_core (.clk(clk), .reset(reset), .auto_ack(ack_on),
      .latency(4'h3), .irq_request(ireq), .irq_vector(ivec),
      .irq_ack(ack), .irq_ack_vector(avec), .ack_count(acks));
   task automatic chk(input string n, input logic [7:0] s, e);
      comparisons++;
      if (s !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      awaddr <= a;
      wdata <= {24'h00_0000, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      r = bresp;
   endtask : wr
   task automatic rd(input logic [11:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      d = rdata[7:0];
      r = rresp;
   endtask : rd
   task automatic rc(input logic [11:0] a, input logic [7:0] e, input string n);
      rd(a);
      chk(n, d, e);
   endtask : rc
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   // ceiling well above the few hundred cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   initial begin
      cyc(5);
      reset <= 1'b0;
      rc(PCM, 8'h3f, "mask reset");
      rc(IEN, 8'h00, "enable reset");
      rc(FLG, 8'h00, "flags reset");
      wr(PCM, 8'hff);
      rc(PCM, 8'h3f, "mask bits");
      wr(IEN, 8'hff);
      rc(IEN, 8'h60, "enable bits");
      wr(MCU, 8'hff);
      rc(MCU, 8'h03, "sense bits");
      rd(12'h0fc);
      chk("unmapped resp", {6'h00, r}, {6'h00, epiu_pkg::RESP_SLVERR});
      chk("unmapped data", d, 8'h00);
      wr(IEN, 8'h00);
      $display("test registers done");
      for (int i = 0; i < 6; i++) begin
         wr(MCU, {6'h00, sense[i]});
         wr(FLG, 8'h60);
         pin <= pv[i];
         cyc(6);
         rc(FLG, fe[i], "edge flag");
      end
      $display("test sense modes done");
      wr(CTL, 8'h00);
      wr(MCU, 8'h02);
      wr(FLG, 8'h60);
      pin <= 1'b0;
      cyc(6);
      rc(FLG, 8'h00, "stopped clock");
      wr(CTL, 8'h03);
      wr(MCU, 8'h00);
      wr(IEN, 8'h40);
      cyc(4);
      chk("level request", {7'h00, ireq}, 8'h01);
      chk("level vector", {4'h0, ivec}, {4'h0, epiu_pkg::VEC_EXT});
      rc(FLG, 8'h00, "level flag");
      pin <= 1'b1;
      cyc(6);
      chk("level gone", {7'h00, ireq}, 8'h00);
      $display("test level done");
      wr(CTL, 8'h02);
      wr(MCU, 8'h02);
      wr(FLG, 8'h60);
      pin <= 1'b0;
      cyc(6);
      chk("global off", {7'h00, ireq}, 8'h00);
      chk("wake", {7'h00, wake}, 8'h01);
      wr(CTL, 8'h03);
      cyc(3);
      chk("global on", {7'h00, ireq}, 8'h01);
      ack_on <= 1'b1;
      cyc(10);
      chk("acks", acks, 8'h01);
      rc(FLG, 8'h00, "ack clears");
      ack_on <= 1'b0;
      pin <= 1'b1;
      $display("test enables done");
      wr(IEN, 8'h20);
      wr(PCM, 8'h01);
      wr(FLG, 8'h60);
      pci <= 6'h02;
      cyc(6);
      rc(FLG, 8'h00, "masked input");
      pci <= 6'h03;
      cyc(6);
      rc(FLG, 8'h20, "pin change");
      chk("pc vector", {4'h0, ivec}, {4'h0, epiu_pkg::VEC_PC});
      wr(MSK, 8'h20);
      cyc(2);
      chk("irq on", {7'h00, irq}, 8'h01);
      wr(MSK, 8'h00);
      cyc(2);
      chk("irq masked", {7'h00, irq}, 8'h00);
      wr(MSK, 8'h20);
      wr(FLG, 8'h20);
      cyc(2);
      chk("irq cleared", {7'h00, irq}, 8'h00);
      rc(FLG, 8'h00, "pc cleared");
      $display("test pin change done");
      tally_and_finish();
   end
endmodule : epiu_top_bench
bind epiu_top epiu_top_sva i_sva (.clk(clk), .reset(reset),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata), .irq_request(irq_request),
   .irq_vector(irq_vector), .wake_request(wake_request), .irq(irq));
